// ==== ddrg_pkg.sv ====
// package: timing constants, command codes, register map and fields of the timing guard
package ddrg_pkg;
   // host clock period in picoseconds (100 MHz)
   localparam int CLK_PS = 10000;
   // counter width shared by all spacing timers
   localparam int CW = 12;

   // ps to clocks: divide by the average period and round up, never below one
   function automatic int ns2cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // larger of a clock count and a time converted to clocks
   function automatic int maxc(input int nck, input int ps);
      return (nck > ns2cyc(ps)) ? nck : ns2cyc(ps);
   endfunction

   // activate spacing within a bank group
   localparam int RRD_NCK = 4;
   localparam int RRD_2K_PS = 6400;
   localparam int RRD_2K_SLOW_PS = 7500;
   localparam int RRD_1K_PS = 4900;
   // four-activate window per page size
   localparam int FAW_2K_NCK = 28;
   localparam int FAW_2K_PS = 30000;
   localparam int FAW_1K_NCK = 20;
   localparam int FAW_1K_PS = 21000;
   localparam int FAW_HK_NCK = 16;
   localparam int FAW_HK_PS = 10875;
   // write to read, read to precharge, write recovery
   localparam int WTR_S_NCK = 2;
   localparam int WTR_S_PS = 2500;
   localparam int WTR_L_NCK = 4;
   localparam int WTR_L_PS = 7500;
   localparam int RTP_NCK = 4;
   localparam int RTP_PS = 7500;
   localparam int WR_PS = 15000;
   localparam int CRC_NCK = 5;
   localparam int CRC_SLOW_NCK = 4;
   localparam int CRC_PS = 3750;
   localparam int RP_PS = 14320;
   // mode register and calibration timing
   localparam int MRD_NCK = 8;
   localparam int MOD_NCK = 24;
   localparam int MOD_PS = 15000;
   localparam int MPRR_NCK = 1;
   localparam int CAL_NCK = 3;
   localparam int CAL_PS = 3748;
   localparam int CPDED_NCK = 4;
   localparam int DLLK_NCK = 1024;
   localparam int ZQINIT_NCK = 1024;
   localparam int ZQOPER_NCK = 512;
   localparam int ZQCS_NCK = 128;
   // reset and self-refresh exit
   localparam int XPR_NCK = 5;
   localparam int RFC_PS = 350000;
   localparam int RFC4_PS = 160000;
   localparam int EXIT_EXTRA_PS = 10000;

   // derived clock counts
   localparam int RRD_2K_CYC = maxc(RRD_NCK, RRD_2K_PS);
   localparam int RRD_2K_SLOW_CYC = maxc(RRD_NCK, RRD_2K_SLOW_PS);
   localparam int RRD_1K_CYC = maxc(RRD_NCK, RRD_1K_PS);
   localparam int FAW_2K_CYC = maxc(FAW_2K_NCK, FAW_2K_PS);
   localparam int FAW_1K_CYC = maxc(FAW_1K_NCK, FAW_1K_PS);
   localparam int FAW_HK_CYC = maxc(FAW_HK_NCK, FAW_HK_PS);
   localparam int WTR_S_CYC = maxc(WTR_S_NCK, WTR_S_PS);
   localparam int WTR_L_CYC = maxc(WTR_L_NCK, WTR_L_PS);
   localparam int RTP_CYC = maxc(RTP_NCK, RTP_PS);
   localparam int WR_CYC = ns2cyc(WR_PS);
   localparam int CRC_CYC = maxc(CRC_NCK, CRC_PS);
   localparam int CRC_SLOW_CYC = maxc(CRC_SLOW_NCK, CRC_PS);
   localparam int RP_CYC = ns2cyc(RP_PS);
   localparam int MOD_CYC = maxc(MOD_NCK, MOD_PS);
   localparam int CAL_CYC = maxc(CAL_NCK, CAL_PS);
   localparam int XPR_CYC = maxc(XPR_NCK, RFC_PS + EXIT_EXTRA_PS);
   localparam int XS_CYC = ns2cyc(RFC_PS + EXIT_EXTRA_PS);
   localparam int XS_ABORT_CYC = ns2cyc(RFC4_PS + EXIT_EXTRA_PS);

   // commands that software may launch
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
      CMD_WRA = 4'h4, CMD_PRE = 4'h5, CMD_MRS = 4'h6, CMD_MPR_RD = 4'h7,
      CMD_MPR_WR = 4'h8, CMD_ZQCL = 4'h9, CMD_ZQCS = 4'ha, CMD_SRX = 4'hb,
      CMD_SRX_ABORT = 4'hc, CMD_SAVE_ENTER = 4'hd, CMD_SAVE_EXIT = 4'he,
      CMD_CKE_UP = 4'hf
   } ddrg_cmd_t;

   // register byte offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0c;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

   // config fields
   localparam int CF_PAGE = 0;
   localparam int CF_SLOW = 2;
   localparam int CF_CRCDM = 3;
   localparam int CF_CAL = 4;
   localparam int CF_PRE2 = 5;
   localparam int CF_CWL = 6;
   localparam int CF_AL = 11;
   localparam int CF_PL = 16;
   localparam int CF_WRP = 19;
   // command register fields
   localparam int CD_CODE = 0;
   localparam int CD_BA = 4;
   localparam int CD_BG = 6;
   localparam int CD_DEVSEL = 8;
   // status fields and page size codes
   localparam int ST_PEND = 0;
   localparam int ST_REFUSED = 1;
   localparam logic [1:0] PAGE_2K = 2'h0;
   localparam logic [1:0] PAGE_1K = 2'h1;
endpackage

// ==== ddrg_timer.sv ====
// spacing countdown: holds the longest outstanding wait and flags when it has run out
`timescale 1ns/10ps
`default_nettype none
module ddrg_timer
   import ddrg_pkg::*;
#(
   parameter int W = CW
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [W-1:0] loadVal,
   output logic expired
);
   logic [W-1:0] cnt_reg; // cycles still to wait
   logic [W-1:0] decVal; // count after this cycle
   logic [W-1:0] reqVal; // count a new load asks for

   // a load of n lets the next command go n cycles later
   assign decVal = (cnt_reg != '0) ? W'(cnt_reg - 1'b1) : '0;
   assign reqVal = (loadVal != '0) ? W'(loadVal - 1'b1) : '0;
   assign expired = (cnt_reg == '0);

   // keep the longer of the running and the new wait
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt_reg <= '0;
      end else if (load && (reqVal > decVal)) begin
         cnt_reg <= reqVal;
      end else begin
         cnt_reg <= decVal;
      end
   end
endmodule
`default_nettype wire

// ==== ddrg_act_window.sv ====
// rolling four-activate window: four slots, each busy for one window after an activate
`timescale 1ns/10ps
`default_nettype none
module ddrg_act_window
   import ddrg_pkg::*;
#(
   parameter int SLOTS = 4
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic act,
   input wire logic [CW-1:0] windowCyc,
   output logic actOk
);
   logic [SLOTS-1:0] slotFree; // slot has no activate in its window
   logic [SLOTS-1:0] slotLoad; // slot takes this activate

   // the lowest free slot records a new activate
   genvar i;
   generate
      for (i = 0; i < SLOTS; i++) begin : g_slot
         if (i == 0) begin : g_first
            assign slotLoad[i] = act && slotFree[i];
         end else begin : g_rest
            assign slotLoad[i] = act && slotFree[i] && (slotFree[i-1:0] == '0);
         end
         ddrg_timer u_slot (
            .mclk(mclk),
            .reset_n(reset_n),
            .load(slotLoad[i]),
            .loadVal(windowCyc),
            .expired(slotFree[i])
         );
      end
   endgenerate

   // a fifth activate waits until the oldest window closes
   assign actOk = (slotFree != '0);
endmodule
`default_nettype wire

// ==== ddrg_guard.sv ====
// host command sequencer that spaces rank commands by their timing constraints
// Operation
// - 2KB same-group activates spaced, 6.4/7.5 ns
// - 1KB/half-KB same-group activates spaced 4.9 ns
// - at most four activates per rolling window
// - other-group read waits short write-read delay
// - same-group read waits long write-read delay
// - precharge waits read-to-precharge after read
// - write recovery 15 ns, longer with CRC+DM
// - CRC+DM lengthens both write-read delays
// - mode register commands eight clocks apart
// - other commands wait mode update delay
// - two recovery clocks after MPR read
// - MPR write waits update plus AL plus PL
// - autoprecharge write blocks activate WR plus tRP
// - CAL mode: chip select leads command
// - CAL mode lengthens mode spacing and update
// - per-device write: data bit zero held low
// - two-clock preamble only at fast grades
// - clock held valid after power-saving entry
// - power-saving exit waits exit plus DLL lock
// - calibration waits 1024, 512, 128 clocks
// - reset exit waits max(5, refresh+10 ns)
// - self-refresh exit and abort delays
// - refresh cycle time taken as 350 ns
// - times rounded up to whole clocks
`timescale 1ns/10ps
`default_nettype none
module ddrg_guard
   import ddrg_pkg::*;
#(
   parameter int GROUPS = 4,
   parameter int BANKS_PER_GROUP = 4,
   parameter bit FAST_GRADE = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [7:0] swAddr,
   input wire logic [31:0] swWdata,
   input wire logic swWr,
   input wire logic swRd,
   output logic [31:0] swRdata,
   output logic ddrCke,
   output logic ddrCsN,
   output logic ddrCmdValid,
   output logic [3:0] ddrCmdCode,
   output logic [1:0] ddrBg,
   output logic [1:0] ddrBa,
   output logic ddrDq0Out,
   output logic ddrDq0Oe,
   output logic ddrPreamble2,
   output logic ddrClkHold
);
   localparam int BANKS = GROUPS * BANKS_PER_GROUP;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_LEAD = 4'h2, ST_ISSUE = 4'h4, ST_HOLD = 4'h8
   } ddrg_state_t;

   ddrg_state_t state_reg, state_next; // sequencer state
   logic [31:0] config_reg; // software configuration
   logic [3:0] code_reg; // pending command
   logic [1:0] bg_reg; // pending bank group
   logic [1:0] ba_reg; // pending bank
   logic devSel_reg; // pending mode write targets one device
   logic pend_reg; // a command waits to be issued
   logic refused_reg; // sticky: command written while one pending
   logic cke_reg; // clock enable driven to the rank
   logic calDone_reg; // power-up calibration already done
   logic [CW-1:0] lead_reg; // cycles left before command in lead phase
   logic [15:0] count_reg; // commands issued
   logic [31:0] rdata_reg; // read data, one cycle after strobe
   logic csLead_reg; // chip select pulse ahead of command

   // decoded configuration
   wire [1:0] cfgPage = config_reg[CF_PAGE +: 2];
   wire cfgSlow = config_reg[CF_SLOW];
   wire cfgCrcDm = config_reg[CF_CRCDM];
   wire cfgCal = config_reg[CF_CAL];
   wire [CW-1:0] cfgCwl = CW'(config_reg[CF_CWL +: 5]);
   wire [CW-1:0] cfgAl = CW'(config_reg[CF_AL +: 5]);
   wire [CW-1:0] cfgPl = CW'(config_reg[CF_PL +: 3]);
   wire [CW-1:0] cfgWrp = CW'(config_reg[CF_WRP +: 5]);

   // register decode
   wire wrConfig = swWr && (swAddr == REG_CONFIG);
   wire wrCmd = swWr && (swAddr == REG_CMD);
   wire wrStatus = swWr && (swAddr == REG_STATUS);

   // command class of the pending command
   wire isAct = (code_reg == CMD_ACT);
   wire isRead = (code_reg == CMD_RD) || (code_reg == CMD_MPR_RD);
   wire isWrite = (code_reg == CMD_WR) || (code_reg == CMD_WRA);
   wire isMode = (code_reg == CMD_MRS) || (code_reg == CMD_SAVE_ENTER) ||
                 (code_reg == CMD_MPR_WR);
   wire fire = (state_reg == ST_ISSUE);
   wire [3:0] bankIdx = {bg_reg, ba_reg};

   // timer outputs
   logic busyOk, modeOk, mrdOk, dllOk, clkFree, fawOk;
   logic [GROUPS-1:0] actGrpOk, rdGrpOk;
   logic [BANKS-1:0] preBankOk, actBankOk;

   // activate spacing by page size and grade
   wire [CW-1:0] rrdCyc = (cfgPage == PAGE_2K) ?
      (cfgSlow ? CW'(RRD_2K_SLOW_CYC) : CW'(RRD_2K_CYC)) : CW'(RRD_1K_CYC);
   wire [CW-1:0] fawCyc = (cfgPage == PAGE_2K) ? CW'(FAW_2K_CYC) :
      (cfgPage == PAGE_1K) ? CW'(FAW_1K_CYC) : CW'(FAW_HK_CYC);
   // CRC+DM extra, four clocks at the slowest grade
   wire [CW-1:0] crcAdd = !cfgCrcDm ? '0 :
      (cfgSlow ? CW'(CRC_SLOW_CYC) : CW'(CRC_CYC));
   // internal write transaction starts four clocks after write latency
   wire [CW-1:0] wrStart = CW'(cfgCwl + CW'(4));
   wire [CW-1:0] wtrSCyc = CW'(wrStart + CW'(WTR_S_CYC) + crcAdd);
   wire [CW-1:0] wtrLCyc = CW'(wrStart + CW'(WTR_L_CYC) + crcAdd);
   wire [CW-1:0] wrRecCyc = CW'(wrStart + CW'(WR_CYC) + crcAdd);
   // programmed WR plus rounded-up precharge period
   wire [CW-1:0] dalCyc = CW'(wrStart + cfgWrp + CW'(RP_CYC));
   // read-to-precharge counted from the internal read
   wire [CW-1:0] rtpCyc = CW'(cfgAl + CW'(RTP_CYC));
   // CAL mode lengthens spacing and update delay
   wire [CW-1:0] calCyc = cfgCal ? CW'(CAL_CYC) : '0;
   wire [CW-1:0] mrdCyc = cfgCal ? CW'(MOD_CYC + CAL_CYC) : CW'(MRD_NCK);
   wire [CW-1:0] modCyc = CW'(CW'(MOD_CYC) + calCyc);
   wire [CW-1:0] mprWrCyc = CW'(modCyc + cfgAl + cfgPl);

   logic [CW-1:0] busyCyc;
   always_comb begin
      case (code_reg)
         CMD_CKE_UP: busyCyc = CW'(XPR_CYC);
         // first calibration after reset is the long one
         CMD_ZQCL: busyCyc = calDone_reg ? CW'(ZQOPER_NCK) : CW'(ZQINIT_NCK);
         CMD_ZQCS: busyCyc = CW'(ZQCS_NCK);
         // exit delays from refresh cycle time
         CMD_SRX: busyCyc = CW'(XS_CYC);
         CMD_SAVE_EXIT: busyCyc = CW'(XS_CYC);
         CMD_SRX_ABORT: busyCyc = CW'(XS_ABORT_CYC);
         CMD_MPR_RD: busyCyc = CW'(MPRR_NCK + 1);
         default: busyCyc = '0;
      endcase
   end

   wire exitCmd = (code_reg == CMD_SRX) || (code_reg == CMD_SAVE_EXIT);

   ddrg_timer u_busy (
      .mclk(mclk), .reset_n(reset_n),
      .load(fire && (busyCyc != '0)), .loadVal(busyCyc), .expired(busyOk)
   );
   ddrg_timer u_mode (
      .mclk(mclk), .reset_n(reset_n), .load(fire && isMode),
      .loadVal((code_reg == CMD_MPR_WR) ? mprWrCyc : modCyc), .expired(modeOk)
   );
   ddrg_timer u_mrd (
      .mclk(mclk), .reset_n(reset_n),
      .load(fire && isMode), .loadVal(mrdCyc), .expired(mrdOk)
   );
   // reads need the DLL relocked after exit
   ddrg_timer u_dll (
      .mclk(mclk), .reset_n(reset_n), .load(fire && exitCmd),
      .loadVal(CW'(XS_CYC + DLLK_NCK)), .expired(dllOk)
   );
   // clock kept valid after power-saving entry
   ddrg_timer u_clk (
      .mclk(mclk), .reset_n(reset_n), .load(fire && (code_reg == CMD_SAVE_ENTER)),
      .loadVal(CW'(MOD_CYC + CPDED_NCK)), .expired(clkFree)
   );
   ddrg_act_window u_faw (
      .mclk(mclk), .reset_n(reset_n),
      .act(fire && isAct), .windowCyc(fawCyc), .actOk(fawOk)
   );

   genvar g, b;
   generate
      for (g = 0; g < GROUPS; g++) begin : g_grp
         wire sameGrp = (bg_reg == 2'(g));
         ddrg_timer u_act (
            .mclk(mclk), .reset_n(reset_n),
            .load(fire && isAct && sameGrp), .loadVal(rrdCyc), .expired(actGrpOk[g])
         );
         // write-to-read, long in the written group
         ddrg_timer u_wtr (
            .mclk(mclk), .reset_n(reset_n), .load(fire && isWrite),
            .loadVal(sameGrp ? wtrLCyc : wtrSCyc), .expired(rdGrpOk[g])
         );
      end
      for (b = 0; b < BANKS; b++) begin : g_bank
         wire sameBank = (bankIdx == 4'(b));
         ddrg_timer u_pre (
            .mclk(mclk), .reset_n(reset_n),
            .load(fire && sameBank && (isRead || isWrite)),
            .loadVal(isWrite ? wrRecCyc : rtpCyc), .expired(preBankOk[b])
         );
         ddrg_timer u_dal (
            .mclk(mclk), .reset_n(reset_n),
            .load(fire && sameBank && (code_reg == CMD_WRA)),
            .loadVal(dalCyc), .expired(actBankOk[b])
         );
      end
   endgenerate

   // command may go only when every relevant timer has run out
   wire legal = busyOk && (isMode ? mrdOk : modeOk) &&
      (!isAct || (actGrpOk[bg_reg] && actBankOk[bankIdx] && fawOk)) &&
      (!isRead || (rdGrpOk[bg_reg] && dllOk)) &&
      ((code_reg != CMD_PRE) || preBankOk[bankIdx]) &&
      (cke_reg || (code_reg == CMD_CKE_UP));
   wire go = pend_reg && legal;
   // a lead phase for chip select or data bit zero setup
   wire needLead = cfgCal || (devSel_reg && (code_reg == CMD_MRS));

   // next-state selection
   always_comb begin
      case (state_reg)
         ST_IDLE: state_next = !go ? ST_IDLE : (needLead ? ST_LEAD : ST_ISSUE);
         ST_LEAD: state_next = (lead_reg <= CW'(1)) ? ST_ISSUE : ST_LEAD;
         ST_ISSUE: state_next = devSel_reg ? ST_HOLD : ST_IDLE;
         ST_HOLD: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // sequencer state and lead counter
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         lead_reg <= '0;
      end else begin
         state_reg <= state_next;
         lead_reg <= (state_reg == ST_IDLE) ? (cfgCal ? calCyc : CW'(1)) :
            CW'(lead_reg - CW'(lead_reg != '0));
      end
   end

   // chip select pulse at the start of the lead in CAL mode
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         csLead_reg <= 1'b0;
      end else begin
         csLead_reg <= (state_reg == ST_IDLE) && go && cfgCal;
      end
   end

   // configuration register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         config_reg <= CONFIG_RESET;
      end else if (wrConfig) begin
         config_reg <= swWdata;
      end
   end

   // pending command capture, refused while one waits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pend_reg <= 1'b0;
         code_reg <= CMD_NOP;
         bg_reg <= '0;
         ba_reg <= '0;
         devSel_reg <= 1'b0;
      end else if (wrCmd && !pend_reg) begin
         pend_reg <= (swWdata[CD_CODE +: 4] != CMD_NOP);
         code_reg <= swWdata[CD_CODE +: 4];
         ba_reg <= swWdata[CD_BA +: 2];
         bg_reg <= swWdata[CD_BG +: 2];
         devSel_reg <= swWdata[CD_DEVSEL];
      end else if (fire) begin
         pend_reg <= 1'b0;
      end
   end

   // sticky refusal flag: a new refusal wins over a clear
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         refused_reg <= 1'b0;
      end else if (wrCmd && pend_reg) begin
         refused_reg <= 1'b1;
      end else if (wrStatus && swWdata[ST_REFUSED]) begin
         refused_reg <= 1'b0;
      end
   end

   // rank clock enable, calibration state and issued count
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cke_reg <= 1'b0;
         calDone_reg <= 1'b0;
         count_reg <= '0;
      end else if (fire) begin
         cke_reg <= cke_reg || (code_reg == CMD_CKE_UP);
         calDone_reg <= calDone_reg || (code_reg == CMD_ZQCL);
         count_reg <= 16'(count_reg + 16'h0001);
      end
   end

   // read data mux, zero for unmapped offsets
   wire [31:0] statusWord = {26'h0, calDone_reg, !busyOk, !clkFree, cke_reg,
                             refused_reg, pend_reg};
   wire [31:0] rdMux = (swAddr == REG_CONFIG) ? config_reg :
      (swAddr == REG_CMD) ? {23'h0, devSel_reg, bg_reg, ba_reg, code_reg} :
      (swAddr == REG_STATUS) ? statusWord :
      (swAddr == REG_COUNT) ? {16'h0, count_reg} : 32'h0;

   // read data register, valid only the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= swRd ? rdMux : 32'h0;
      end
   end

   // pin drive
   assign swRdata = rdata_reg;
   assign ddrCke = cke_reg;
   assign ddrCmdValid = fire;
   assign ddrCmdCode = fire ? code_reg : CMD_NOP;
   assign ddrBg = bg_reg;
   assign ddrBa = ba_reg;
   // chip select with command, or ahead of it in CAL mode
   assign ddrCsN = !(cfgCal ? csLead_reg : fire);
   // data bit zero low across the per-device write
   assign ddrDq0Out = 1'b0;
   assign ddrDq0Oe = devSel_reg && (code_reg == CMD_MRS) && (state_reg != ST_IDLE);
   // two-clock preamble only offered at fast grades
   assign ddrPreamble2 = FAST_GRADE && config_reg[CF_PRE2];
   assign ddrClkHold = !clkFree;
endmodule
`default_nettype wire

// ==== ddrg_guard_props.sv ====
// checker of command spacing seen on the guard's pins
`timescale 1ns/10ps
`default_nettype none
module ddrg_guard_props
   import ddrg_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ddrCke,
   input wire logic ddrCsN,
   input wire logic ddrCmdValid,
   input wire logic [3:0] ddrCmdCode,
   input wire logic [1:0] ddrBg,
   input wire logic ddrDq0Out,
   input wire logic ddrDq0Oe,
   input wire logic ddrPreamble2,
   input wire logic ddrClkHold
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // issue decodes
   wire logic isAct = ddrCmdValid && ddrCmdCode == CMD_ACT;
   wire logic isMrs = ddrCmdValid && ddrCmdCode == CMD_MRS;
   wire logic isCal = ddrCmdValid && (ddrCmdCode == CMD_ZQCL || ddrCmdCode == CMD_ZQCS);
   logic [1:0] lastBg_reg; // group of the latest activate
   logic [11:0] calGap_reg; // cycles since calibration, saturating
   // track last activate group and calibration age
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         lastBg_reg <= 2'h0;
         calGap_reg <= 12'hfff;
      end else begin
         if (isAct) lastBg_reg <= ddrBg;
         if (isCal) calGap_reg <= 12'h000;
         else if (calGap_reg != 12'hfff) calGap_reg <= calGap_reg + 12'h001;
      end
   end
   AST_CKE_FIRST: assert property ($rose(ddrCke) |-> !ddrCmdValid [*8])
      else $error("command too soon after clock enable");
   AST_ACT_GROUP: assert property (isAct |=> !(isAct && ddrBg == lastBg_reg) [*3])
      else $error("same group activates too close");
   AST_WR_RD: assert property ((ddrCmdValid && ddrCmdCode == CMD_WR) |=> !(ddrCmdValid && ddrCmdCode == CMD_RD) [*5])
      else $error("read too soon after write");
   AST_MRS_GAP: assert property (isMrs |=> !isMrs [*7])
      else $error("mode commands too close");
   AST_MOD_WAIT: assert property (isMrs |=> !(ddrCmdValid && ddrCmdCode inside {CMD_ACT, CMD_RD, CMD_WR}) [*8])
      else $error("command inside mode update delay");
   AST_CAL_GAP: assert property (ddrCmdValid && !isCal |-> calGap_reg >= 12'd127)
      else $error("command during calibration");
   AST_CAL_LEAD: assert property (!ddrCsN && !ddrCmdValid |-> ##3 ddrCmdValid)
      else $error("chip select lead wrong");
   AST_DEVSEL_LOW: assert property (isMrs && ddrDq0Oe |->
      !ddrDq0Out && $past(ddrDq0Oe) ##1 ddrDq0Oe && !ddrDq0Out)
      else $error("data bit zero not low while selecting");
   AST_PRE2: assert property (ddrPreamble2 |-> FAST_GRADE)
      else $error("long preamble at slow grade");
   AST_CLK_HOLD: assert property ((ddrCmdValid && ddrCmdCode == CMD_SAVE_ENTER) |-> ##2 ddrClkHold [*8])
      else $error("clock hold missing after power saving entry");
endmodule
bind ddrg_guard ddrg_guard_props #(.FAST_GRADE(FAST_GRADE)) ddrg_guard_props_i (.mclk(mclk),
   .reset_n(reset_n), .ddrCke(ddrCke), .ddrCsN(ddrCsN), .ddrCmdValid(ddrCmdValid),
   .ddrCmdCode(ddrCmdCode), .ddrBg(ddrBg), .ddrDq0Out(ddrDq0Out), .ddrDq0Oe(ddrDq0Oe),
   .ddrPreamble2(ddrPreamble2), .ddrClkHold(ddrClkHold));
`default_nettype wire

// ==== ddrg_dram_model.sv ====
// memory rank model: counts commands it captures
`timescale 1ns/10ps
`default_nettype none
module ddrg_dram_model
   import ddrg_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ddrCke,
   input wire logic ddrCmdValid,
   input wire logic [3:0] ddrCmdCode,
   input wire logic ddrPreamble2,
   output var logic [15:0] seenCnt,
   output logic longPre
);
   assign longPre = ddrPreamble2;
   always_ff @(posedge mclk) begin
      if (!reset_n) seenCnt <= 16'h0;
      else if (ddrCmdValid && (ddrCke || ddrCmdCode == CMD_CKE_UP)) seenCnt <= seenCnt + 16'h1;
   end
endmodule
`default_nettype wire

// ==== ddr4_command_timing_guard_bench.sv ====
// bench of the command timing guard
`timescale 1ns/10ps
`default_nettype none
module ddr4_command_timing_guard_bench
   import ddrg_pkg::*;
;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] swAddr = 8'h00;
   logic [31:0] swWdata = 32'h0;
   logic swWr = 1'b0;
   logic swRd = 1'b0;
   wire logic [31:0] swRdata;
   wire logic ddrCke, ddrCsN, ddrCmdValid, ddrDq0Out, ddrDq0Oe, ddrPreamble2, ddrClkHold;
   wire logic [3:0] ddrCmdCode;
   wire logic [1:0] ddrBg, ddrBa;
   wire logic [15:0] seenCnt;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   int issCyc = 0;
   int nIss = 0;
   int nCmd = 0;
   int cwl, t, t0;
   logic [1:0] rb;
   logic [3:0] lastCode;
   logic [31:0] v;
   ddrg_guard ddrg_guard_i (.mclk, .reset_n, .swAddr, .swWdata, .swWr, .swRd, .swRdata,
      .ddrCke, .ddrCsN, .ddrCmdValid, .ddrCmdCode, .ddrBg, .ddrBa, .ddrDq0Out, .ddrDq0Oe,
      .ddrPreamble2, .ddrClkHold);
   ddrg_dram_model ddrg_dram_model_i (.mclk, .reset_n, .ddrCke, .ddrCmdValid, .ddrCmdCode,
      .ddrPreamble2, .seenCnt, .longPre());
   always #5 mclk = ~mclk;
   // cycle count and issue log
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (ddrCmdValid) begin
         issCyc <= cyc;
         nIss <= nIss + 1;
         lastCode <= ddrCmdCode;
      end
   end
   task automatic summarize();
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // compare for equality, or for a lower bound when ge is set
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input bit ge);
      num_checks++;
      if (ge ? (got < exp) : (got !== exp)) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      swWr <= 1'b1;
      swAddr <= a;
      swWdata <= d;
      @(posedge mclk);
      swWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      swRd <= 1'b1;
      swAddr <= a;
      @(posedge mclk);
      swRd <= 1'b0;
      #1 d = swRdata;
   endtask
   // queue a command, wait for its issue, check code and spacing from ref
   task automatic cmd(input logic [8:0] c, input logic [1:0] g, input logic [1:0] b,
                      input int base, input int min, output int tOut);
      int n = nIss;
      wr(REG_CMD, {23'h0, c[8], g, b, c[3:0]});
      for (int i = 0; i < 3000 && nIss == n; i++) begin
         @(posedge mclk);
         #1;
      end
      chk(nIss != n, 1, 0);
      chk(lastCode, c[3:0], 0);
      chk({ddrBg, ddrBa}, {g, b}, 0);
      chk(issCyc - base, min, 1);
      tOut = issCyc;
      nCmd++;
   endtask
   function automatic logic [31:0] cfg(input int w, input logic crc, input logic cal);
      return (32'(w) << CF_CWL) | (32'(crc) << CF_CRCDM) | (32'(cal) << CF_CAL) | 32'h20;
   endfunction
   initial begin
      #200000;
      failures++;
      summarize();
   end
   initial begin
      void'($urandom(32'h18557846));
      cwl = $urandom % 8;
      rb = 2'($urandom % 4);
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      rd(REG_CONFIG, v);
      chk(v, CONFIG_RESET, 0);
      rd(8'h10, v);
      chk(v, 32'h0, 0);
      wr(REG_CONFIG, cfg(cwl, 1'b0, 1'b0));
      chk(ddrPreamble2, 1'b1, 0);
      cmd(CMD_CKE_UP, 0, 0, 0, 0, t);
      cmd(CMD_ACT, 0, 0, t, XPR_CYC, t0);
      cmd(CMD_ACT, 0, 1, t0, RRD_2K_CYC, t);
      for (int g = 1; g < 4; g++) cmd(CMD_ACT, 2'(g), 2, t0, (g == 3) ? FAW_2K_CYC : 0, t);
      cmd(CMD_WR, rb, 0, t, 0, t);
      cmd(CMD_RD, rb, 0, t, WTR_L_CYC + cwl + 4, t);
      cmd(CMD_PRE, rb, 0, t, RTP_CYC, t);
      cmd(CMD_WR, rb, 0, t, 0, t);
      cmd(CMD_RD, rb + 2'h1, 0, t, WTR_S_CYC + cwl + 4, t);
      wr(REG_CONFIG, cfg(cwl, 1'b1, 1'b0));
      cmd(CMD_WR, rb, 0, t, 0, t0);
      cmd(CMD_PRE, rb, 0, t0, WR_CYC + CRC_CYC + cwl + 4, t);
      cmd(CMD_RD, rb, 0, t0, WTR_L_CYC + CRC_CYC + cwl + 4, t);
      cmd(CMD_WRA, 1, 3, t, 0, t0);
      cmd(CMD_ACT, 1, 3, t0, RP_CYC + cwl + 4, t);
      cmd(CMD_MRS, 0, 0, t, 0, t);
      cmd(CMD_MRS, 0, 0, t, MRD_NCK, t);
      cmd(CMD_ACT, 1, 0, t, MOD_CYC, t);
      cmd(CMD_MPR_RD, 0, 0, t, 0, t);
      cmd(CMD_MPR_WR, 0, 0, t, MPRR_NCK, t);
      cmd(CMD_ACT, 2, 1, t, MOD_CYC, t);
      wr(REG_CONFIG, cfg(cwl, 1'b0, 1'b1));
      cmd({1'b1, 4'h0, CMD_MRS}, 0, 0, t, 0, t);
      cmd(CMD_ACT, 3, 0, t, MOD_CYC + CAL_CYC, t);
      wr(REG_CONFIG, cfg(cwl, 1'b0, 1'b0) | 32'(PAGE_1K));
      cmd(CMD_ZQCL, 0, 0, t, 0, t);
      cmd(CMD_ACT, 0, 0, t, ZQINIT_NCK, t);
      cmd(CMD_ZQCS, 0, 0, t, 0, t);
      cmd(CMD_ACT, 1, 0, t, ZQCS_NCK, t);
      cmd(CMD_ACT, 1, 1, t, RRD_1K_CYC, t);
      cmd(CMD_SAVE_ENTER, 0, 0, t, 0, t);
      cmd(CMD_SAVE_EXIT, 0, 0, t, 0, t0);
      cmd(CMD_ACT, 2, 0, t0, XS_CYC, t);
      cmd(CMD_RD, 2, 0, t0, XS_CYC + DLLK_NCK, t);
      cmd(CMD_SRX, 0, 0, t, 0, t);
      cmd(CMD_ACT, 3, 1, t, XS_CYC, t);
      cmd(CMD_SRX_ABORT, 0, 0, t, 0, t);
      cmd(CMD_ACT, 0, 1, t, XS_ABORT_CYC, t);
      wr(REG_CMD, 32'h1);
      wr(REG_CMD, 32'h1);
      rd(REG_STATUS, v);
      chk(v[ST_REFUSED], 1'b1, 0);
      chk(v[2], 1'b1, 0);
      repeat (100) @(posedge mclk);
      rd(REG_COUNT, v);
      chk(v[15:0], 16'(nCmd + 1), 0);
      chk(seenCnt, 16'(nCmd + 1), 0);
      summarize();
   end
endmodule
`default_nettype wire
